// file: hdl/timer16_capture_compare.sv
// 16-bit timer with capture/compare A and B, AXI4-Lite registers
// assumes pins synchronous to MCLK_I, single outstanding bus access
//
// Contract
// - Reading the counter never captures into register B.
// - A counter read holds the count input; no pulse is lost with CTL_EXT_CLK set.
// - In compare use, register A ignores capture triggers.
// - With A zero in free or edge-clear mode, match fires on 0 to 1.
// - With A zero, match also fires on B edge and one-shot clear.
// - A read colliding with a capture may be odd; capture is exact.
// - A stop colliding with a capture still stores the exact count.
`timescale 1ns/1ps
module timer16_capture_compare
	import tmr_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK_I,
	input  wire logic        RST_B_I,
	// axi4-lite write
	input  wire logic [7:0]  AXI_AWADDR_I,
	input  wire logic        AXI_AWVALID_I,
	output logic             AXI_AWREADY_O,
	input  wire logic [31:0] AXI_WDATA_I,
	input  wire logic [3:0]  AXI_WSTRB_I,
	input  wire logic        AXI_WVALID_I,
	output logic             AXI_WREADY_O,
	output logic [1:0]       AXI_BRESP_O,
	output logic             AXI_BVALID_O,
	input  wire logic        AXI_BREADY_I,
	// axi4-lite read
	input  wire logic [7:0]  AXI_ARADDR_I,
	input  wire logic        AXI_ARVALID_I,
	output logic             AXI_ARREADY_O,
	output logic [31:0]      AXI_RDATA_O,
	output logic [1:0]       AXI_RRESP_O,
	output logic             AXI_RVALID_O,
	input  wire logic        AXI_RREADY_I,
	// timer pins
	input  wire logic        CAPTURE_INPUT_A_I,
	input  wire logic        COUNT_IN_I,
	input  wire logic        SHARED_PIN_I,
	output logic             SHARED_PIN_O,
	output logic             SHARED_PIN_OE_B_O,
	// interrupt
	output logic             IRQ_O
);

	// ********************************
	// registers
	// ********************************
	logic [15:0] cca;
	logic [15:0] ccb;
	logic [7:0]  ctrl;
	logic [2:0]  status;
	logic [2:0]  mask;
	logic        have_aw;
	logic        have_w;
	logic [7:0]  awaddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        tout;

	cnt_if cif ();

	count_core u_core (
		.clk_i   (MCLK_I),
		.rst_b_i (RST_B_I),
		.cif     (cif.core)
	);

	logic [2:0] rise;
	logic [2:0] fall;

	edge_detect #(.N(3)) u_edge (
		.clk_i   (MCLK_I),
		.rst_b_i (RST_B_I),
		.pin_i   ({COUNT_IN_I, SHARED_PIN_I, CAPTURE_INPUT_A_I}),
		.rise_o  (rise),
		.fall_o  (fall)
	);

	// ********************************
	// bus decode
	// ********************************
	wire        aw_hs    = AXI_AWVALID_I & AXI_AWREADY_O;
	wire        w_hs     = AXI_WVALID_I & AXI_WREADY_O;
	wire        ar_hs    = AXI_ARVALID_I & AXI_ARREADY_O;
	wire        do_write = have_aw & have_w & ~AXI_BVALID_O;
	wire [31:0] wbe      = {{8{wstrb[3]}}, {8{wstrb[2]}},
	                        {8{wstrb[1]}}, {8{wstrb[0]}}};
	wire [31:0] wm       = wdata & wbe;
	wire        wr_cca   = do_write & (awaddr == OFS_CCA);
	wire        wr_ccb   = do_write & (awaddr == OFS_CCB);
	wire        wr_ctrl  = do_write & (awaddr == OFS_CTRL);
	wire        wr_stat  = do_write & (awaddr == OFS_STAT);
	wire        wr_mask  = do_write & (awaddr == OFS_MASK);
	wire        wr_ok    = wr_cca | wr_ccb | wr_ctrl | wr_stat | wr_mask |
	                       (awaddr == OFS_COUNT);
	wire        rd_ok    = (AXI_ARADDR_I <= OFS_MASK) &
	                       (AXI_ARADDR_I[1:0] == 2'b00);
	wire [31:0] rd_word  =
		(AXI_ARADDR_I == OFS_COUNT) ? {16'h0000, cif.value} :
		(AXI_ARADDR_I == OFS_CCA)   ? {16'h0000, cca} :
		(AXI_ARADDR_I == OFS_CCB)   ? {16'h0000, ccb} :
		(AXI_ARADDR_I == OFS_CTRL)  ? {24'h000000, ctrl} :
		(AXI_ARADDR_I == OFS_STAT)  ? {29'h0, status} :
		(AXI_ARADDR_I == OFS_MASK)  ? {29'h0, mask} :
		32'h00000000;

	// ********************************
	// timer control
	// ********************************
	mode_t mode;
	assign mode = mode_t'(ctrl[CTL_MODE_LO +: 2]);

	wire run     = (mode != MODE_STOP);
	wire edge_a  = ctrl[CTL_FALL_A] ? fall[0] : rise[0];
	wire edge_b  = rise[1] & ~ctrl[CTL_OUT_EN];
	wire oneshot = wr_ctrl & wbe[CTL_ONESHOT] &
	               wdata[CTL_ONESHOT] & run;
	wire match_a = cif.step & (cif.value == cca);
	wire match_b = cif.step & (cif.value == ccb) & ~ctrl[CTL_CCB_CAP];
	wire cap_a   = edge_b & ctrl[CTL_CCA_CAP];
	wire cap_b   = edge_a & ctrl[CTL_CCB_CAP];
	// zero in A: match on 0 to 1 step, B edge or one-shot clear
	wire cca_zero  = (cca == CC_RST);
	wire ev_a      = match_a | (cca_zero & (edge_b | oneshot));

	assign cif.pulse = run & (ctrl[CTL_EXT_CLK] ? rise[2] : 1'b1);
	assign cif.hold  = ar_hs & (AXI_ARADDR_I == OFS_COUNT);
	assign cif.clear = (mode == MODE_CLR_MATCH & match_a & ~cca_zero) |
	                   (mode == MODE_CLR_EDGE & edge_a) | oneshot;

	wire [2:0] events      = {match_b, cif.wrap, ev_a};
	wire [2:0] stat_clr    = wr_stat ? wm[2:0] : 3'h0;
	// a new event wins over a clear in the same cycle
	wire [2:0] next_status = (status & ~stat_clr) | events;

	// ********************************
	// register updates
	// ********************************
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			cca <= CC_RST;
		end else if (cap_a) begin
			cca <= cif.value;
		end else if (wr_cca) begin
			cca <= (cca & ~wbe[15:0]) | wm[15:0];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			ccb <= CC_RST;
		end else if (cap_b) begin
			ccb <= cif.value;
		end else if (wr_ccb) begin
			ccb <= (ccb & ~wbe[15:0]) | wm[15:0];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			ctrl   <= CTRL_RST;
			mask   <= STAT_RST;
			status <= STAT_RST;
			IRQ_O  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl <= ((ctrl & ~wbe[7:0]) | wm[7:0]) &
				        ~(8'h01 << CTL_ONESHOT);
			end
			if (wr_mask) begin
				mask <= (mask & ~wbe[2:0]) | wm[2:0];
			end
			status <= next_status;
			IRQ_O  <= |(next_status & (wr_mask ?
			          ((mask & ~wbe[2:0]) | wm[2:0]) : mask));
		end
	end

	// timer output toggles on each match of A
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			tout              <= 1'b0;
			SHARED_PIN_O      <= 1'b0;
			SHARED_PIN_OE_B_O <= 1'b1;
		end else begin
			tout              <= tout ^ (ev_a & ctrl[CTL_OUT_EN]);
			SHARED_PIN_O      <= tout ^ (ev_a & ctrl[CTL_OUT_EN]);
			SHARED_PIN_OE_B_O <= ~ctrl[CTL_OUT_EN];
		end
	end

	// ********************************
	// axi4-lite slave
	// ********************************
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			AXI_AWREADY_O <= 1'b1;
			AXI_WREADY_O  <= 1'b1;
			AXI_BVALID_O  <= 1'b0;
			AXI_BRESP_O   <= RESP_OKAY;
			have_aw       <= 1'b0;
			have_w        <= 1'b0;
			awaddr        <= 8'h00;
			wdata         <= 32'h00000000;
			wstrb         <= 4'h0;
		end else begin
			if (aw_hs) begin
				AXI_AWREADY_O <= 1'b0;
				have_aw       <= 1'b1;
				awaddr        <= AXI_AWADDR_I;
			end
			if (w_hs) begin
				AXI_WREADY_O <= 1'b0;
				have_w       <= 1'b1;
				wdata        <= AXI_WDATA_I;
				wstrb        <= AXI_WSTRB_I;
			end
			if (do_write) begin
				have_aw      <= 1'b0;
				have_w       <= 1'b0;
				AXI_BVALID_O <= 1'b1;
				AXI_BRESP_O  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (AXI_BVALID_O && AXI_BREADY_I) begin
				AXI_BVALID_O  <= 1'b0;
				AXI_AWREADY_O <= 1'b1;
				AXI_WREADY_O  <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			AXI_ARREADY_O <= 1'b1;
			AXI_RVALID_O  <= 1'b0;
			AXI_RDATA_O   <= 32'h00000000;
			AXI_RRESP_O   <= RESP_OKAY;
		end else if (ar_hs) begin
			AXI_ARREADY_O <= 1'b0;
			AXI_RVALID_O  <= 1'b1;
			AXI_RDATA_O   <= rd_word;
			AXI_RRESP_O   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (AXI_RVALID_O && AXI_RREADY_I) begin
			AXI_ARREADY_O <= 1'b1;
			AXI_RVALID_O  <= 1'b0;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);

	AST_READ_NO_CAPTURE: assert property (
		(cif.hold && !cap_b && !wr_ccb) |=> $stable(ccb))
		else $error("counter read changed register B");
	AST_CMP_IGNORES_TRIG: assert property (
		(edge_b && !ctrl[CTL_CCA_CAP] && !wr_cca) |=> $stable(cca))
		else $error("compare register A took a capture");
	AST_ZERO_WRAP_MATCH: assert property (
		(cif.step && cif.value == CNT_RST && cca_zero &&
		 (mode == MODE_FREE || mode == MODE_CLR_EDGE))
		|=> status[ST_MATCH_A] && (IRQ_O || !mask[ST_MATCH_A]))
		else $error("zero compare missed on 0 to 1 step");
	AST_ZERO_B_EDGE: assert property (
		(edge_b && cca_zero) |=> status[ST_MATCH_A])
		else $error("B edge with zero A gave no match");
	AST_CAPTURE_EXACT: assert property (
		cap_a |=> (cca == $past(cif.value)))
		else $error("capture into A stored wrong value");
	AST_STOP_FROZEN: assert property (
		(mode == MODE_STOP && $past(mode) == MODE_STOP &&
		 !$past(cif.hold) && !cif.clear) |=> $stable(cif.value))
		else $error("counter moved while stopped");
	AST_OVF_FLAG: assert property (
		cif.wrap |=> status[ST_OVF])
		else $error("wrap did not set overflow");
	// output use masks input b; a read freezes the count
	AST_ZERO_ONESHOT: assert property (
		(oneshot && cca_zero) |=> status[ST_MATCH_A])
		else $error("one-shot clear with zero A gave no match");
	AST_EDGE_B_MASKED: assert property (
		(rise[1] && ctrl[CTL_OUT_EN] && !wr_cca) |=> $stable(cca))
		else $error("input B edge acted while output enabled");
	AST_HOLD_FREEZE: assert property (
		(cif.hold && !cif.clear) |=> $stable(cif.value))
		else $error("counter stepped during a read");

	COV_CAPTURE_A: cover property (cap_a ##[1:20] ar_hs);
	COV_WRAP: cover property (cif.wrap);
	COV_CLR_MATCH: cover property (mode == MODE_CLR_MATCH && cif.clear);
	COV_READ_HOLD: cover property (cif.hold && cif.pulse);
	COV_ONESHOT_ZERO: cover property (oneshot && cca_zero);

endmodule

// file: pkg/tmr_pkg.sv
// constants of the 16-bit capture/compare timer
// assumes one clock domain and an AXI4-Lite register port
package tmr_pkg;

	// ********************************
	// register offsets (byte addresses)
	// ********************************
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_CCA   = 8'h04;
	localparam logic [7:0] OFS_CCB   = 8'h08;
	localparam logic [7:0] OFS_CTRL  = 8'h0c;
	localparam logic [7:0] OFS_STAT  = 8'h10;
	localparam logic [7:0] OFS_MASK  = 8'h14;

	// ********************************
	// control fields
	// ********************************
	localparam int CTL_MODE_LO = 0;
	localparam int CTL_CCA_CAP = 2;
	localparam int CTL_CCB_CAP = 3;
	localparam int CTL_EXT_CLK = 4;
	localparam int CTL_OUT_EN  = 5;
	localparam int CTL_FALL_A  = 6;
	localparam int CTL_ONESHOT = 7;

	// ********************************
	// status fields
	// ********************************
	localparam int ST_MATCH_A = 0;
	localparam int ST_OVF     = 1;
	localparam int ST_MATCH_B = 2;

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [2:0]  STAT_RST = 3'h0;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] CC_RST   = 16'h0000;
	localparam logic [15:0] CNT_MAX  = 16'hffff;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_STOP      = 2'b00,
		MODE_FREE      = 2'b01,
		MODE_CLR_EDGE  = 2'b10,
		MODE_CLR_MATCH = 2'b11
	} mode_t;

endpackage

// file: pkg/cnt_if.sv
// signals between the timer top and its counter core
// assumes both ends on the same clock
`timescale 1ns/1ps
interface cnt_if;
	logic        pulse;
	logic        hold;
	logic        clear;
	logic        step;
	logic        wrap;
	logic [15:0] value;
	modport core (input pulse, hold, clear, output step, wrap, value);
	modport ctl  (output pulse, hold, clear, input step, wrap, value);
endinterface

// file: hdl/edge_detect.sv
// rising and falling edge detection for synchronous pin inputs
// assumes inputs already synchronous to the clock
`timescale 1ns/1ps
module edge_detect
	import tmr_pkg::*;
#(
	parameter int N = 3
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// pins
	input  wire logic [N-1:0] pin_i,
	// edges, one cycle each
	output logic      [N-1:0] rise_o,
	output logic      [N-1:0] fall_o
);

	logic [N-1:0] last;

	for (genvar i = 0; i < N; i++) begin : g_edge
		always_ff @(posedge clk_i) begin
			if (!rst_b_i) begin
				last[i] <= 1'b0;
			end else begin
				last[i] <= pin_i[i];
			end
		end
		assign rise_o[i] = pin_i[i] & ~last[i];
		assign fall_o[i] = ~pin_i[i] & last[i];
	end

endmodule

// file: hdl/count_core.sv
// 16-bit up counter with read hold-off and deferred count
// assumes hold lasts at most one cycle at a time
`timescale 1ns/1ps
module count_core
	import tmr_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// control side
	cnt_if.core       cif
);

	logic        pending;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	wire         apply = ~cif.hold & (cif.pulse | pending);

	// a pulse seen during a read is kept, unless a kept pulse is already pending
	assign next_cnt  = cif.clear ? CNT_RST :
	                   apply ? cnt + 16'h0001 : cnt;
	assign cif.step  = apply;
	assign cif.wrap  = apply & ~cif.clear & (cnt == CNT_MAX);
	assign cif.value = cnt;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pending <= 1'b0;
			cnt     <= CNT_RST;
		end else begin
			// a kept pulse waits while new pulses keep coming
			pending <= cif.hold ? (cif.pulse | pending) :
			           (cif.pulse & pending);
			cnt     <= next_cnt;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	AST_HOLD_NO_LOSS: assert property (
		(cif.hold && cif.pulse && !cif.clear) ##1 !cif.hold |-> cif.step)
		else $error("count pulse lost during read hold");
	AST_WRAP_ZERO: assert property (
		cif.wrap |=> (cnt == CNT_RST))
		else $error("counter did not wrap to zero");

endmodule

// file: verification/pin_model.sv
// pin-side model: capture input a, count input, capture input b
// assumes clk_i is the timer clock; pins change just after an edge
`timescale 1ns/1ps
module pin_model (
	// clock
	input  wire logic clk_i,
	// pins toward the timer
	output logic      cap_a_o,
	output logic      cnt_o,
	output logic      cap_b_o
);
	initial begin
		cap_a_o = 1'b0;
		cnt_o   = 1'b0;
		cap_b_o = 1'b0;
	end
	task automatic drive(input int sel, input logic lvl);
		case (sel)
			0: cap_a_o <= lvl;
			1: cnt_o <= lvl;
			default: cap_b_o <= lvl;
		endcase
	endtask
	// n high pulses, each held hi cycles
	task automatic pulse(input int sel, input int n, input int hi);
		repeat (n) begin
			@(posedge clk_i);
			drive(sel, 1'b1);
			repeat (hi) @(posedge clk_i);
			drive(sel, 1'b0);
			@(posedge clk_i);
		end
	endtask
endmodule

// file: verification/tb_timer16_capture_compare.sv
// self-checking bench of the capture/compare timer
// assumes one clock; pin_model drives the timer pins
`timescale 1ns/1ps
module tb_timer16_capture_compare
	import tmr_pkg::*;
();
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  rs;
	} row_t;
	logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready;
	logic        pa, pc, pb, pin_o, oe_b, irq, shared_w;
	logic [7:0]  awaddr, araddr;
	logic [3:0]  wstrb;
	logic [31:0] wdata, rdata, v;
	logic [1:0]  bresp, rresp, r;
	int          fail_count, total_checks;
	row_t        rows [6];

	assign shared_w = oe_b ? pb : pin_o;

	timer16_capture_compare dut (.MCLK_I(clk), .RST_B_I(rst_b),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
		.AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
		.AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
		.AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid),
		.AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
		.AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
		.CAPTURE_INPUT_A_I(pa), .COUNT_IN_I(pc), .SHARED_PIN_I(shared_w),
		.SHARED_PIN_O(pin_o), .SHARED_PIN_OE_B_O(oe_b), .IRQ_O(irq));
	pin_model pm (.clk_i(clk), .cap_a_o(pa), .cnt_o(pc), .cap_b_o(pb));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] rs);
		int i;
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awready && !aw_done) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid) break;
		end
		if (i == 100) begin
			fail_count++;
			end_of_test();
		end else begin
			rs = bresp;
			bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (i == 100) begin
			fail_count++;
			end_of_test();
		end else begin
			d = rdata;
			rs = rresp;
			rready <= 1'b0;
		end
	endtask
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		chk(n, e, d);
		chk("rresp", RESP_OKAY, rs);
	endtask
	task automatic reset_dut;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
	endtask
	task automatic wait_irq(input int n);
		int i;
		for (i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
		if (i == n) begin
			fail_count++;
			end_of_test();
		end
	endtask

	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		fail_count = 0;
		total_checks = 0;
		rows = '{'{OFS_CCA, 32'h0000_1234, 32'h1234, RESP_OKAY},
			'{OFS_CCB, 32'hffff_abcd, 32'habcd, RESP_OKAY},
			'{OFS_MASK, 32'h0000_00ff, 32'h7, RESP_OKAY},
			'{OFS_COUNT, 32'h0000_5555, 32'h0, RESP_OKAY},
			'{8'h18, 32'h1, 32'h0, RESP_SLVERR},
			'{8'h06, 32'h1, 32'h0, RESP_SLVERR}};
		reset_dut();
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d, r);
			chk("bresp", rows[k].rs, r);
			rd(rows[k].a, v, r);
			chk("rdata", rows[k].e, v);
			chk("rresp", rows[k].rs, r);
		end
		// ************ byte lanes ************
		wstrb <= 4'h1;
		wr(OFS_CCA, 32'h0000_ffff, r);
		wstrb <= 4'hf;
		rchk("cca strb", OFS_CCA, 32'h12ff);
		// ************ second reset ************
		reset_dut();
		chk("irq", 1'b0, irq);
		chk("oe_b", 1'b1, oe_b);
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("cca", OFS_CCA, 32'h0);
		rchk("mask", OFS_MASK, 32'h0);
		// ************ counting, match, irq ************
		wr(OFS_MASK, 32'h1, r);
		wr(OFS_CTRL, 32'h11, r);
		pm.pulse(1, 5, 3);
		rchk("count", OFS_COUNT, 32'h5);
		rchk("stat", OFS_STAT, 32'h5);
		wr(OFS_STAT, 32'h7, r);
		fork
			rd(OFS_COUNT, v, r);
			pm.pulse(1, 3, 1);
		join
		rchk("count", OFS_COUNT, 32'h8);
		pm.pulse(2, 1, 3);
		rchk("cca", OFS_CCA, 32'h0);
		rchk("stat", OFS_STAT, 32'h1);
		chk("irq", 1'b1, irq);
		wr(OFS_MASK, 32'h0, r);
		repeat (2) @(posedge clk);
		chk("irq", 1'b0, irq);
		wr(OFS_STAT, 32'h7, r);
		wr(OFS_MASK, 32'h1, r);
		// ************ capture ************
		wr(OFS_CTRL, 32'h1d, r);
		fork
			rd(OFS_CCA, v, r);
			pm.pulse(2, 1, 1);
		join
		rchk("cca", OFS_CCA, 32'h8);
		pm.pulse(0, 1, 3);
		pm.pulse(1, 2, 1);
		rchk("count", OFS_COUNT, 32'ha);
		rchk("ccb", OFS_CCB, 32'h8);
		wr(OFS_CTRL, 32'h3d, r);
		repeat (2) @(posedge clk);
		chk("oe_b", 1'b0, oe_b);
		pm.pulse(2, 1, 3);
		rchk("cca", OFS_CCA, 32'h8);
		// match toggles the output; its own edge must not capture
		wr(OFS_CCA, 32'hb, r);
		pm.pulse(1, 2, 1);
		chk("pin_o", 1'b1, pin_o);
		rchk("cca", OFS_CCA, 32'hb);
		// ************ wrap with a zero ************
		wr(OFS_CTRL, 32'h01, r);
		wr(OFS_CCA, 32'h0, r);
		wr(OFS_STAT, 32'h7, r);
		rchk("stat", OFS_STAT, 32'h0);
		wait_irq(70000);
		rchk("stat", OFS_STAT, 32'h3);
		wr(OFS_STAT, 32'h3, r);
		repeat (2) @(posedge clk);
		chk("irq", 1'b0, irq);
		// ************ one-shot and clear modes ************
		wr(OFS_STAT, 32'h7, r);
		wr(OFS_CTRL, 32'h91, r);
		rchk("count", OFS_COUNT, 32'h0);
		rchk("stat", OFS_STAT, 32'h1);
		wr(OFS_CCA, 32'h3, r);
		wr(OFS_CTRL, 32'h13, r);
		wr(OFS_STAT, 32'h7, r);
		pm.pulse(1, 5, 1);
		rchk("count", OFS_COUNT, 32'h1);
		rchk("stat", OFS_STAT, 32'h1);
		wr(OFS_CTRL, 32'h52, r);
		pm.pulse(1, 2, 1);
		pm.drive(0, 1'b1);
		rchk("count", OFS_COUNT, 32'h3);
		pm.drive(0, 1'b0);
		rchk("count", OFS_COUNT, 32'h0);
		end_of_test();
	end
endmodule
